// *** verilog/art_pkg.sv ***
// constants and carrier types for the auto-reload timer zero block
package art_pkg;

  // register offsets on the host register port
  localparam logic [7:0] ART_OFS_CONTROL     = 8'h4f;
  localparam logic [7:0] ART_OFS_RELOAD_LOW  = 8'h50;
  localparam logic [7:0] ART_OFS_RELOAD_HIGH = 8'h51;
  localparam logic [7:0] ART_OFS_COUNT_LOW   = 8'h52;
  localparam logic [7:0] ART_OFS_COUNT_HIGH  = 8'h53;

  // control register field positions
  localparam int         ART_CTL_RUN_BIT      = 2;
  localparam int         ART_CTL_LOW_IRQ_BIT  = 5;
  localparam logic [7:0] ART_CTL_USED_MASK    = 8'h24;

  // reset values
  localparam logic [7:0] ART_RST_CONTROL     = 8'h04;
  localparam logic [7:0] ART_RST_RELOAD_LOW  = 8'h8d;
  localparam logic [7:0] ART_RST_RELOAD_HIGH = 8'h34;
  localparam logic [15:0] ART_RST_COUNT      = 16'h0000;
  localparam logic [7:0] ART_RD_UNMAPPED     = 8'h00;

  // timing: count rate is the system clock divided by twelve
  localparam int         ART_DIV_CYCLES = 12;
  localparam logic [3:0] ART_DIV_LAST   = 4'(ART_DIV_CYCLES - 1);

  // one register access, write and read strobes with address and data
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } art_req_s;

endpackage

// *** verilog/art_prescaler.sv ***
// divide-by-twelve count enable for the timer
`timescale 1ns/1ns
`default_nettype none
module art_prescaler
  import art_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // control and enable pulse
  input  wire logic run,
  output logic      tick
);

  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;

  // phase counter holds while halted
  assign next_div_cnt = !run ? div_cnt :
                        (div_cnt == ART_DIV_LAST) ? 4'h0 : div_cnt + 4'h1;
  assign tick         = run && (div_cnt == ART_DIV_LAST); // RULE_07

  // divider phase register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // a tick is followed by at least eleven quiet cycles
  AST_TICK_GAP: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_07
    tick |=> !tick [*8] ##1 !tick [*3])
    else $error("tick repeated before twelve cycles");

endmodule
`default_nettype wire

// *** verilog/art_timer.sv ***
// auto-reload 16-bit timer zero with its host-visible registers
// Overview of operation
// RULE_01: counting happens only while control bit 2 (run) is one.
// RULE_02: with control bit 5 and timer interrupts enabled, low-byte overflow interrupts.
// RULE_03: control bits 7:6, 4:3 and 1:0 read zero, writes ignored.
// RULE_04: reload low byte register is readable and writable.
// RULE_05: reload high byte register is readable and writable.
// RULE_06: count high byte is a readable, writable register beside the low byte.
// RULE_07: count advances once every twelve system clocks, always auto-reload.
// RULE_08: on wrap from ffff the reload value loads and overflow flag sets.
// RULE_09: with timer interrupts enabled each 16-bit overflow interrupts.
// RULE_10: after reset the run bit is one, so the timer counts.
// RULE_11: writing a count byte replaces it at once; counting continues from it.
`timescale 1ns/1ns
`default_nettype none
module art_timer
  import art_pkg::*;
(
  // clock and reset
  input  wire logic      clk_sys,
  input  wire logic      sys_rst,
  // host register port
  input  wire art_req_s  reg_req,
  output logic [7:0]     reg_rdata,
  // shared interrupt logic outside the block
  input  wire logic      irq_enable,
  output logic           ovf_flag_set,
  output logic           low_ovf_event,
  output logic           irq_pulse
);

  // register state
  logic [7:0]  control;
  logic [7:0]  reload_low;
  logic [7:0]  reload_high;
  logic [15:0] count;

  // next values
  logic [7:0]  next_control;
  logic [15:0] next_count;
  logic [7:0]  next_rdata;

  // decode of the host access
  wire logic wr_control  = reg_req.wr && (reg_req.addr == ART_OFS_CONTROL);
  wire logic wr_rl_low   = reg_req.wr && (reg_req.addr == ART_OFS_RELOAD_LOW);
  wire logic wr_rl_high  = reg_req.wr && (reg_req.addr == ART_OFS_RELOAD_HIGH);
  wire logic wr_cnt_low  = reg_req.wr && (reg_req.addr == ART_OFS_COUNT_LOW);
  wire logic wr_cnt_high = reg_req.wr && (reg_req.addr == ART_OFS_COUNT_HIGH);
  wire logic cnt_written = wr_cnt_low || wr_cnt_high;

  // control fields
  wire logic ctl_run    = control[ART_CTL_RUN_BIT];
  wire logic ctl_low_en = control[ART_CTL_LOW_IRQ_BIT];

  // count events
  logic tick;
  wire logic [15:0] reload   = {reload_high, reload_low};
  wire logic [15:0] count_up = count + 16'h0001;
  wire logic        wrap16   = tick && (count == 16'hffff);
  wire logic        wrap8    = tick && (count[7:0] == 8'hff);

  // count enable from the divider, gated by run
  art_prescaler u_prescaler (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .run     (ctl_run), // RULE_01
    .tick    (tick)
  );

  // only the run and low-byte enable bits are kept
  assign next_control = wr_control ? (reg_req.wdata & ART_CTL_USED_MASK) : control; // RULE_03

  // a host byte write wins over the count step in the same cycle
  assign next_count = wr_cnt_low  ? {count[15:8], reg_req.wdata} : // RULE_11
                      wr_cnt_high ? {reg_req.wdata, count[7:0]} :  // RULE_06
                      wrap16      ? reload :                        // RULE_08
                      tick        ? count_up :                      // RULE_07
                      count;

  // read multiplexer, unmapped offsets read zero
  assign next_rdata =
    (reg_req.addr == ART_OFS_CONTROL)     ? control :
    (reg_req.addr == ART_OFS_RELOAD_LOW)  ? reload_low :
    (reg_req.addr == ART_OFS_RELOAD_HIGH) ? reload_high :
    (reg_req.addr == ART_OFS_COUNT_LOW)   ? count[7:0] :
    (reg_req.addr == ART_OFS_COUNT_HIGH)  ? count[15:8] :
    ART_RD_UNMAPPED;

  // control and reload registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      control     <= ART_RST_CONTROL; // RULE_10
      reload_low  <= ART_RST_RELOAD_LOW;
      reload_high <= ART_RST_RELOAD_HIGH;
    end else begin
      control <= next_control;
      if (wr_rl_low) begin
        reload_low <= reg_req.wdata; // RULE_04
      end
      if (wr_rl_high) begin
        reload_high <= reg_req.wdata; // RULE_05
      end
    end
  end

  // live count
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count <= ART_RST_COUNT;
    end else begin
      count <= next_count;
    end
  end

  // read data, event and interrupt pulses
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata     <= ART_RD_UNMAPPED;
      ovf_flag_set  <= 1'b0;
      low_ovf_event <= 1'b0;
      irq_pulse     <= 1'b0;
    end else begin
      if (reg_req.rd) begin
        reg_rdata <= next_rdata;
      end
      ovf_flag_set  <= wrap16; // RULE_08
      low_ovf_event <= wrap8;
      irq_pulse     <= irq_enable && (wrap16 || (ctl_low_en && wrap8)); // RULE_09 RULE_02
    end
  end

  // halted timer holds its count unless the host writes it
  AST_HALT_HOLDS: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_01
    !ctl_run && !cnt_written |=> $stable(count))
    else $error("count moved while halted");

  // low-byte wrap with its enable gives an interrupt next cycle
  AST_LOW_IRQ: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_02
    wrap8 && ctl_low_en && irq_enable |=> irq_pulse)
    else $error("low byte overflow interrupt missing");

  // unused control bits stay zero
  AST_UNUSED_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_03
    (control & ~ART_CTL_USED_MASK) == 8'h00)
    else $error("unused control bit set");

  // reload low write lands
  AST_RELOAD_LOW_RW: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_04
    wr_rl_low |=> reload_low == $past(reg_req.wdata))
    else $error("reload low not stored");

  // reload high write lands
  AST_RELOAD_HIGH_RW: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_05
    wr_rl_high |=> reload_high == $past(reg_req.wdata))
    else $error("reload high not stored");

  // count high read returns the live upper byte
  AST_COUNT_HIGH_RD: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_06
    reg_req.rd && reg_req.addr == ART_OFS_COUNT_HIGH |=> reg_rdata == $past(count[15:8]))
    else $error("count high read wrong");

  // count changes only on a tick or a host write
  AST_STEP_ON_TICK: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_07
    !tick && !cnt_written |=> $stable(count))
    else $error("count moved without tick");

  // wrap reloads and flags overflow together
  AST_WRAP_RELOAD: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_08
    wrap16 && !cnt_written |=> count == $past(reload) && ovf_flag_set)
    else $error("wrap did not reload");

  // every 16-bit overflow interrupts when enabled
  AST_OVF_IRQ: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_09
    ovf_flag_set && $past(irq_enable) |-> irq_pulse)
    else $error("overflow interrupt missing");

  // first cycle after reset runs
  AST_RESET_RUNS: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_10
    $past(sys_rst) |-> ctl_run)
    else $error("timer not running after reset");

  // low count write takes effect next cycle
  AST_COUNT_LOW_WR: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_11
    wr_cnt_low |=> count[7:0] == $past(reg_req.wdata))
    else $error("count low write lost");

  // reload low read returns the stored byte
  AST_RELOAD_LOW_RD: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_04
    reg_req.rd && reg_req.addr == ART_OFS_RELOAD_LOW |=> reg_rdata == $past(reload_low))
    else $error("reload low read wrong");

  // reload high read returns the stored byte
  AST_RELOAD_HIGH_RD: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_05
    reg_req.rd && reg_req.addr == ART_OFS_RELOAD_HIGH |=> reg_rdata == $past(reload_high))
    else $error("reload high read wrong");

  // control read shows zero in the unused bits
  AST_CONTROL_RD: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_03
    reg_req.rd && reg_req.addr == ART_OFS_CONTROL |=> (reg_rdata & ~ART_CTL_USED_MASK) == 8'h00)
    else $error("unused control bit read as one");

  // count high write takes effect next cycle
  AST_COUNT_HIGH_WR: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_06
    wr_cnt_high |=> count[15:8] == $past(reg_req.wdata))
    else $error("count high write lost");

  // a plain tick steps the count by one
  AST_COUNT_STEP: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_07
    tick && !wrap16 && !cnt_written |=> count == $past(count_up))
    else $error("count did not step by one");

  // overflow pulse lasts a single cycle
  AST_OVF_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_08
    ovf_flag_set |=> !ovf_flag_set)
    else $error("overflow pulse too long");

  // low byte wrap always reports its event
  AST_LOW_EVENT: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_02
    wrap8 |=> low_ovf_event)
    else $error("low byte wrap event missing");

  // low byte wrap without its enable stays quiet
  AST_LOW_IRQ_GATED: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_02
    wrap8 && !wrap16 && !ctl_low_en |=> !irq_pulse)
    else $error("low byte interrupt without enable");

  // no interrupt while timer interrupts are off
  AST_IRQ_NEEDS_ENABLE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_09
    !irq_enable |=> !irq_pulse)
    else $error("interrupt while disabled");

endmodule
`default_nettype wire

// *** verification/tb_art_timer.sv ***
// self-checking testbench for the auto-reload timer zero block
`timescale 1ns/1ns
`default_nettype none
module tb_art_timer;
  import art_pkg::*;
  logic       clk_sys;
  logic       sys_rst;
  art_req_s   reg_req;
  logic [7:0] reg_rdata;
  logic       irq_enable;
  logic       ovf_flag_set;
  logic       low_ovf_event;
  logic       irq_pulse;
  logic [7:0] d;
  int         errors;
  int         n_tests;
  int         n;

  art_timer art_timer_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .irq_enable(irq_enable), .ovf_flag_set(ovf_flag_set), .low_ovf_event(low_ovf_event), .irq_pulse(irq_pulse));

  // system clock, 8 ns period
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // compare seen against expected
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys);
    #1 reg_req.wr = 1'b0;
  endtask

  // one-cycle read strobe, data taken after the answering edge
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    #1 reg_req.rd = 1'b0;
    d = reg_rdata;
    chk(d, exp);
  endtask

  // bounded wait for a low-byte or full overflow pulse, n counts edges
  task automatic wait_ev(input logic low);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (((low ? low_ovf_event : ovf_flag_set) !== 1'b1) && n < 60);
    if (n >= 60) begin
      errors++;
      $display("BAD %0t no timer event", $time);
    end
  endtask

  task automatic t_reset();
    rdchk(ART_OFS_CONTROL, 8'h04);
    rdchk(ART_OFS_RELOAD_LOW, 8'h8d);
    rdchk(ART_OFS_RELOAD_HIGH, 8'h34);
    rdchk(ART_OFS_COUNT_LOW, 8'h00);
    repeat (4) @(posedge clk_sys);
    rdchk(ART_OFS_COUNT_LOW, 8'h01);
    rdchk(ART_OFS_COUNT_HIGH, 8'h00);
    rdchk(8'h60, ART_RD_UNMAPPED);
    $display("test reset done");
  endtask

  task automatic t_ctl();
    wr(ART_OFS_CONTROL, 8'hff);
    rdchk(ART_OFS_CONTROL, 8'h24);
    wr(ART_OFS_CONTROL, 8'h00);
    wr(ART_OFS_COUNT_LOW, 8'h5a);
    rdchk(ART_OFS_COUNT_LOW, 8'h5a);
    repeat (30) @(posedge clk_sys);
    rdchk(ART_OFS_COUNT_LOW, 8'h5a);
    $display("test control done");
  endtask

  task automatic t_ovf();
    wr(ART_OFS_RELOAD_LOW, 8'hfe);
    wr(ART_OFS_RELOAD_HIGH, 8'hff);
    wr(ART_OFS_COUNT_LOW, 8'hfe);
    wr(ART_OFS_COUNT_HIGH, 8'hff);
    rdchk(ART_OFS_COUNT_HIGH, 8'hff);
    rdchk(ART_OFS_RELOAD_LOW, 8'hfe);
    rdchk(ART_OFS_RELOAD_HIGH, 8'hff);
    irq_enable = 1'b1;
    wr(ART_OFS_CONTROL, 8'h04);
    wait_ev(1'b0);
    chk(8'(irq_pulse), 8'h01);
    chk(8'(low_ovf_event), 8'h01);
    wait_ev(1'b0);
    chk(8'(n), 8'h18);
    wr(ART_OFS_CONTROL, 8'h00);
    rdchk(ART_OFS_COUNT_LOW, 8'hfe);
    rdchk(ART_OFS_COUNT_HIGH, 8'hff);
    $display("test overflow done");
  endtask

  // low byte wrap with a given control value and enable level
  task automatic t_low(input logic [7:0] c, input logic en, input logic [7:0] exp);
    wr(ART_OFS_CONTROL, 8'h00);
    wr(ART_OFS_COUNT_LOW, 8'hfe);
    wr(ART_OFS_COUNT_HIGH, 8'h00);
    irq_enable = en;
    wr(ART_OFS_CONTROL, c);
    wait_ev(1'b1);
    chk(8'(irq_pulse), exp);
    chk(8'(ovf_flag_set), 8'h00);
    $display("test low byte done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #100000;
    errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    errors = 0;
    n_tests = 0;
    n = 0;
    sys_rst = 1'b1;
    irq_enable = 1'b0;
    reg_req = '0;
    repeat (12) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    t_reset();
    t_ctl();
    t_ovf();
    t_low(8'h24, 1'b1, 8'h01);
    t_low(8'h04, 1'b1, 8'h00);
    t_low(8'h24, 1'b0, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
